// >>> dv/csc_ctrl_chk.sv
// Port assertions for the state and conversion control block.
// Bound to every csc_ctrl instance; one clock domain, async low reset.
`timescale 1ns/1ps
module csc_ctrl_chk (
	// Clock, reset and bus pins
	input logic i_clk_sys, i_reset_n, i_scl, i_sda,
	// Host and status
	input logic i_wr_valid, i_rd_valid, o_rd_valid, o_access_err, o_ready,
	input logic [2:0] i_wr_addr, i_rd_addr,
	input logic [7:0] i_wr_data,
	input logic [15:0] i_sample_x, i_sample_y, i_sample_z, i_sample_temp, o_rd_data,
	input logic [1:0] o_state
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	a_state_legal: assert property (o_state != 2'h3)
		else $error("illegal state code");
	a_rd_answer: assert property (i_rd_valid |=> o_rd_valid)
		else $error("read not answered");
	a_rd_cause: assert property (o_rd_valid |-> $past(i_rd_valid))
		else $error("read answer without request");
	a_blocked_zero: assert property (o_access_err |-> o_rd_valid && o_rd_data == 16'h0000)
		else $error("blocked read leaks data");
	a_result_blocked: assert property (i_rd_valid && i_rd_addr inside {[3'h2:3'h5]} && o_state != 2'h2 |=> o_access_err)
		else $error("result read not blocked");
	a_config_blocked: assert property (i_rd_valid && i_rd_addr == 3'h6 && o_state == 2'h2 |=> o_access_err)
		else $error("config read not blocked");
	a_idle_ready: assert property (o_state != 2'h2 |-> o_ready)
		else $error("conversion outside measurement");
	a_ready_fall: assert property ($fell(o_ready) |-> o_state == 2'h2 ##1 !o_ready [*8])
		else $error("ready low too briefly");
	a_abort_ready: assert property ($past(o_state) == 2'h2 && o_state == 2'h1 |-> o_ready)
		else $error("abort left ready low");
endmodule
bind csc_ctrl csc_ctrl_chk csc_ctrl_chk_i (.i_clk_sys, .i_reset_n, .i_scl, .i_sda, .i_wr_valid,
	.i_wr_addr, .i_wr_data, .i_rd_valid, .i_rd_addr, .i_sample_x, .i_sample_y, .i_sample_z,
	.i_sample_temp, .o_rd_data, .o_rd_valid, .o_access_err, .o_ready, .o_state);

// >>> dv/csc_ctrl_test.sv
// Self-checking bench for csc_ctrl with a pin-level host model.
// Needs csc_ctrl, csc_host_model and the bound checker.
`timescale 1ns/1ps
`include "csc_consts.vh"
module csc_ctrl_test;
	logic i_clk_sys = '0, i_reset_n = '0, i_wr_valid = '0, i_rd_valid = '0;
	logic [2:0] i_wr_addr = '0, i_rd_addr = '0;
	logic [7:0] i_wr_data = '0;
	// Full-scale and zero samples give the same result whether averaged or summed
	logic [15:0] i_sample_x = 16'hFFFF, i_sample_y = 16'h0000;
	logic [15:0] i_sample_z = 16'hFFFF, i_sample_temp = 16'hFFFF;
	logic i_scl, i_sda, o_rd_valid, o_access_err, o_ready;
	logic [15:0] o_rd_data;
	logic [1:0] o_state;
	int bad_count = 0, checked = 0, cyc = 0, n;
	csc_ctrl #(.BASE_TICKS(4)) csc_ctrl_i (.i_clk_sys, .i_reset_n, .i_scl, .i_sda, .i_wr_valid,
		.i_wr_addr, .i_wr_data, .i_rd_valid, .i_rd_addr, .i_sample_x, .i_sample_y, .i_sample_z,
		.i_sample_temp, .o_rd_data, .o_rd_valid, .o_access_err, .o_ready, .o_state);
	csc_host_model csc_host_model_i (.o_scl(i_scl), .o_sda(i_sda));
	always #50 i_clk_sys = ~i_clk_sys;
	task end_of_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Whole run is under a thousand cycles
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_of_test();
		end
	end
	task check(string name, logic [17:0] seen, logic [17:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(logic [2:0] a, logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr_valid <= 1'b1;
		i_wr_addr <= a;
		i_wr_data <= d;
		@(posedge i_clk_sys);
		i_wr_valid <= 1'b0;
	endtask
	task cmd(logic [2:0] a, logic [7:0] d);
		wr(a, d);
		csc_host_model_i.send_stop();
		repeat (6) @(posedge i_clk_sys);
	endtask
	task rd(logic [2:0] a, logic e, logic [15:0] d, logic [15:0] m = 16'hFFFF);
		@(posedge i_clk_sys);
		i_rd_valid <= 1'b1;
		i_rd_addr <= a;
		@(posedge i_clk_sys);
		i_rd_valid <= 1'b0;
		#1;
		check("read", {o_rd_valid, o_access_err, o_rd_data & m}, {1'b1, e, d});
	endtask
	task st(logic [1:0] s, logic r);
		#1;
		check("state_ready", {o_state, o_ready}, {s, r});
	endtask
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		st(2'h0, 1'b1);
		rd(`CSC_ADR_OPST, 1'b0, 16'h0042);
		rd(`CSC_ADR_CFG1, 1'b0, 16'h00A6);
		rd(`CSC_ADR_RES1, 1'b1, 16'h0000);
		wr(`CSC_ADR_OPST, 8'h02);
		repeat (20) @(posedge i_clk_sys);
		st(2'h0, 1'b1);
		csc_host_model_i.send_stop();
		repeat (6) @(posedge i_clk_sys);
		st(2'h1, 1'b1);
		rd(`CSC_ADR_TEMP, 1'b1, 16'h0000);
		cmd(`CSC_ADR_CFG1, 8'h01);
		rd(`CSC_ADR_CFG1, 1'b0, 16'h0001);
		cmd(`CSC_ADR_OPST, 8'h83);
		st(2'h2, 1'b0);
		n = 0;
		while (o_ready !== 1'b1 && n < 3000) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		// Time field 1 gives 8 ticks of 10 clocks; the start came a few clocks earlier
		check("duration", n >= 60 && n <= 90, 1);
		rd(`CSC_ADR_RES1, 1'b0, 16'hFFFF);
		rd(`CSC_ADR_RES2, 1'b0, 16'h0000);
		rd(`CSC_ADR_RES3, 1'b0, 16'hFFFF);
		rd(`CSC_ADR_TEMP, 1'b0, 16'hFFFF);
		rd(`CSC_ADR_STATUS, 1'b0, 16'h0003);
		rd(`CSC_ADR_CFG1, 1'b1, 16'h0000);
		rd(`CSC_ADR_OPST, 1'b0, 16'h0003);
		st(2'h2, 1'b1);
		cmd(`CSC_ADR_OPST, 8'h80);
		st(2'h2, 1'b0);
		cmd(`CSC_ADR_OPST, 8'h02);
		st(2'h1, 1'b1);
		cmd(`CSC_ADR_OPST, 8'h03);
		rd(`CSC_ADR_RES1, 1'b0, 16'h0000);
		rd(`CSC_ADR_STATUS, 1'b0, 16'h0000);
		cmd(`CSC_ADR_CFG1, 8'h11);
		cmd(`CSC_ADR_OPST, 8'h02);
		rd(`CSC_ADR_CFG1, 1'b0, 16'h0001);
		cmd(`CSC_ADR_OPST, 8'h08);
		st(2'h0, 1'b1);
		rd(`CSC_ADR_CFG1, 1'b0, 16'h00A6);
		end_of_test();
	end
endmodule

// >>> dv/csc_host_model.sv
// Bus host model: drives the raw clock and data pins; its only task generates a Stop.
// Pins idle high as with pull-ups; the clock stands still outside frames.
`timescale 1ns/1ps
module csc_host_model (
	// Bus pins
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Data low under a low clock first, so no false Start is seen
	task send_stop;
		// Step off the clock edge so the pins never move in the sampling time step
		#10 o_scl = 1'b0;
		#400 o_sda = 1'b0;
		#400 o_scl = 1'b1;
		#400 o_sda = 1'b1;
		#400;
	endtask
endmodule

// >>> logic/csc_consts.vh
// Constants for the colour sensor state and conversion control block.
// Included by every design file of the block; holds definitions only.
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// Operational state register fields
`define CSC_OPST_SS 7
`define CSC_OPST_PWRDN 6
`define CSC_OPST_SWRES 3
`define CSC_OPST_FLD_HI 2
`define CSC_OPST_FLD_LO 0
`define CSC_OPST_RESET 8'h42

// Device state field encodings
`define CSC_FLD_NOP 3'h0
`define CSC_FLD_CFG 3'h2
`define CSC_FLD_MEAS 3'h3

// First configuration register fields and reset value
`define CSC_CFG_GAIN_HI 7
`define CSC_CFG_GAIN_LO 4
`define CSC_CFG_TIME_HI 3
`define CSC_CFG_TIME_LO 0
`define CSC_CFG_RESET 8'hA6

// Register read and write addresses
`define CSC_ADR_OPST 3'h0
`define CSC_ADR_STATUS 3'h1
`define CSC_ADR_TEMP 3'h2
`define CSC_ADR_RES1 3'h3
`define CSC_ADR_RES2 3'h4
`define CSC_ADR_RES3 3'h5
`define CSC_ADR_CFG1 3'h6

// Status register bits
`define CSC_ST_DONE 0
`define CSC_ST_SAT 1
`define CSC_ST_BUSY 2
`define CSC_ST_ABORT 3

// Operating states
`define CSC_S_PWRDN 2'h0
`define CSC_S_CFG 2'h1
`define CSC_S_MEAS 2'h2

// Timing, temperature channel gain and result ceiling
`define CSC_SYS_CLK_HZ 10000000
`define CSC_CONV_CLK_HZ 1000000
`define CSC_TEMP_GAIN 4'h0
`define CSC_RES_MAX 16'hFFFF

`endif

// >>> logic/csc_conv_chan.v
// One converter channel: integrates its input sample on each conversion tick.
// Assumes the caller clears it at the start of a conversion and on abort.
`timescale 1ns/1ps
`include "csc_consts.vh"

module csc_conv_chan #(
	parameter ACC_W = 24
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_reset_n,
	// Control
	input wire i_clear,
	input wire i_run,
	input wire i_tick,
	input wire [3:0] i_gain,
	input wire [15:0] i_sample,
	// Result
	output reg [15:0] o_value,
	output reg o_sat
);

	reg [ACC_W-1:0] acc_reg;
	wire [ACC_W-1:0] step = {{(ACC_W-16){1'b0}}, i_sample >> i_gain};
	wire [ACC_W:0] sum = {1'b0, acc_reg} + {1'b0, step};

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_reg <= {ACC_W{1'b0}};
			o_value <= 16'h0000;
			o_sat <= 1'b0;
		end else if (i_clear) begin
			acc_reg <= {ACC_W{1'b0}};
			o_value <= 16'h0000;
			o_sat <= 1'b0;
		end else if (i_run && i_tick) begin
			// Accumulator saturates rather than wrapping so bright light never reads dark
			acc_reg <= sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];
			if (sum[ACC_W:16] != {(ACC_W-15){1'b0}}) begin
				o_value <= `CSC_RES_MAX;
				o_sat <= 1'b1;
			end else begin
				o_value <= sum[15:0];
			end
		end
	end

endmodule

// >>> logic/csc_ctrl.v
// State and conversion control of a three-channel colour sensor with die temperature.
// Assumes a byte engine on i_clk_sys delivers host writes; bus pins are raw and asynchronous.
// Summary of operation
// - At each conversion end the three optical channel values go into their own result registers.
// - A temperature channel converts alongside and its result is stored at conversion end.
// - The ready output stays low for the whole of a running conversion.
// - Completion is marked by ready rising and then staying high.
// - A status register tells the host about the latest conversion.
// - Apart from power down the block is in exactly one of configuration or measurement state.
// - The operating state is chosen by the device state field in the low three state bits.
// - After power-on or software reset the block is in power down yet still takes writes.
// - Writing zero to the power-down bit enters the state selected by the device state field.
// - The gain field of the first config register sets responsivity and its time field the duration.
// - Going from measurement to configuration is immediate, aborts and clears results and status.
// - Measurement blocks config access; configuration blocks result access and conversions.
// - Field value 011b means measurement and 000b leaves the state unchanged.
// - A host command takes effect only after the write transfer ends with a Stop.
`timescale 1ns/1ps
`include "csc_consts.vh"

module csc_ctrl #(
	parameter BASE_TICKS = 1024,
	parameter CNT_W = 24
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_reset_n,
	// Raw bus pins, sampled for the Stop condition
	input wire i_scl,
	input wire i_sda,
	// Host byte writes from the bus engine
	input wire i_wr_valid,
	input wire [2:0] i_wr_addr,
	input wire [7:0] i_wr_data,
	// Host reads
	input wire i_rd_valid,
	input wire [2:0] i_rd_addr,
	// Converter samples
	input wire [15:0] i_sample_x,
	input wire [15:0] i_sample_y,
	input wire [15:0] i_sample_z,
	input wire [15:0] i_sample_temp,
	// Read answer and status
	output reg [15:0] o_rd_data,
	output reg o_rd_valid,
	output reg o_access_err,
	output reg o_ready,
	output reg [1:0] o_state
);

	localparam integer TICK_DIV = `CSC_SYS_CLK_HZ / `CSC_CONV_CLK_HZ;
	localparam [7:0] TICK_LAST = TICK_DIV[7:0] - 8'h01;
	// Operating state codes seen on o_state
	localparam [1:0] ST_PWRDN = `CSC_S_PWRDN;
	localparam [1:0] ST_CFG = `CSC_S_CFG;
	localparam [1:0] ST_MEAS = `CSC_S_MEAS;

	// Pin synchronisers; the first stage feeds only the second
	reg scl_s1, scl_s2, sda_s1, sda_s2, sda_d;
	wire stop_seen = scl_s2 && sda_s2 && !sda_d;

	reg [7:0] div_reg;
	wire tick = (div_reg == TICK_LAST);

	reg [7:0] opstate_reg, cfg_reg, opstate_pend, cfg_pend;
	reg opstate_pend_v, cfg_pend_v;
	reg [3:0] status_reg;
	reg busy_reg;
	reg [CNT_W-1:0] cnt_reg;
	reg [15:0] res_reg [0:3];
	reg conv_clear;

	wire [3:0] gain = cfg_reg[`CSC_CFG_GAIN_HI:`CSC_CFG_GAIN_LO];
	wire [3:0] ctime = cfg_reg[`CSC_CFG_TIME_HI:`CSC_CFG_TIME_LO];
	wire [CNT_W-1:0] conv_last = (BASE_TICKS[CNT_W-1:0] << ctime) - {{(CNT_W-1){1'b0}}, 1'b1};
	// Results are taken one cycle after the last tick so that tick's sample is included
	wire last_tick = busy_reg && tick && (cnt_reg == conv_last);
	reg fin_reg;
	wire conv_end = busy_reg && fin_reg;

	wire [63:0] samples = {i_sample_temp, i_sample_z, i_sample_y, i_sample_x};
	wire [63:0] values;
	wire [3:0] sats;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			csc_conv_chan #(.ACC_W(CNT_W)) u_chan (
				.i_clk_sys(i_clk_sys),
				.i_reset_n(i_reset_n),
				.i_clear(conv_clear),
				.i_run(busy_reg),
				.i_tick(tick),
				.i_gain((g == 3) ? `CSC_TEMP_GAIN : gain),
				.i_sample(samples[16*g+15:16*g]),
				.o_value(values[16*g+15:16*g]),
				.o_sat(sats[g])
			);
		end
	endgenerate

	// Maps a device state field value to the next state; unknown codes keep the state
	function [1:0] field_state;
		input [2:0] code;
		input [1:0] cur;
		begin
			case (code)
				`CSC_FLD_MEAS: field_state = ST_MEAS;
				`CSC_FLD_CFG: field_state = ST_CFG;
				default: field_state = cur;
			endcase
		end
	endfunction

	// Read access is blocked by state
	function rd_allowed;
		input [2:0] adr;
		input [1:0] st;
		begin
			case (adr)
				`CSC_ADR_OPST, `CSC_ADR_STATUS: rd_allowed = 1'b1;
				`CSC_ADR_CFG1: rd_allowed = (st != ST_MEAS);
				`CSC_ADR_TEMP, `CSC_ADR_RES1, `CSC_ADR_RES2, `CSC_ADR_RES3:
					rd_allowed = (st == ST_MEAS);
				default: rd_allowed = 1'b0;
			endcase
		end
	endfunction

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			div_reg <= 8'h00;
		end else begin
			scl_s1 <= i_scl;
			scl_s2 <= scl_s1;
			sda_s1 <= i_sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			div_reg <= tick ? 8'h00 : div_reg + 8'h01;
		end
	end

	// Next state of a staged state write; a no-op code keeps the stored field
	reg [1:0] nst;
	reg [2:0] nfield;
	always @* begin
		nfield = opstate_pend[`CSC_OPST_FLD_HI:`CSC_OPST_FLD_LO];
		if (nfield == `CSC_FLD_NOP)
			nfield = opstate_reg[`CSC_OPST_FLD_HI:`CSC_OPST_FLD_LO];
		nst = field_state(nfield, (o_state == ST_PWRDN) ? ST_CFG : o_state);
		if (opstate_pend[`CSC_OPST_PWRDN])
			nst = ST_PWRDN;
	end

	// Command application, state control and conversion
	integer i;
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			opstate_reg <= `CSC_OPST_RESET;
			cfg_reg <= `CSC_CFG_RESET;
			opstate_pend <= 8'h00;
			cfg_pend <= 8'h00;
			opstate_pend_v <= 1'b0;
			cfg_pend_v <= 1'b0;
			status_reg <= 4'h0;
			busy_reg <= 1'b0;
			fin_reg <= 1'b0;
			cnt_reg <= {CNT_W{1'b0}};
			conv_clear <= 1'b0;
			o_ready <= 1'b1;
			o_state <= ST_PWRDN;
			for (i = 0; i < 4; i = i + 1)
				res_reg[i] <= 16'h0000;
		end else begin
			conv_clear <= 1'b0;
			fin_reg <= last_tick;
			// Writes are only staged; a transfer cut short without Stop stays staged until the next Stop applies it
			if (i_wr_valid && i_wr_addr == `CSC_ADR_OPST) begin
				opstate_pend <= i_wr_data;
				opstate_pend_v <= 1'b1;
			end
			if (i_wr_valid && i_wr_addr == `CSC_ADR_CFG1) begin
				cfg_pend <= i_wr_data;
				cfg_pend_v <= 1'b1;
			end
			if (busy_reg && tick)
				cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			if (conv_end) begin
				busy_reg <= 1'b0;
				o_ready <= 1'b1;
				opstate_reg[`CSC_OPST_SS] <= 1'b0;
				for (i = 0; i < 4; i = i + 1)
					res_reg[i] <= values[16*i+15-:16];
				status_reg[`CSC_ST_DONE] <= 1'b1;
				status_reg[`CSC_ST_SAT] <= |sats;
				status_reg[`CSC_ST_BUSY] <= 1'b0;
			end
			if (stop_seen) begin
				opstate_pend_v <= 1'b0;
				cfg_pend_v <= 1'b0;
				// Config register is locked while measuring
				if (cfg_pend_v && o_state != ST_MEAS)
					cfg_reg <= cfg_pend;
				if (opstate_pend_v && opstate_pend[`CSC_OPST_SWRES]) begin
					opstate_reg <= `CSC_OPST_RESET;
					cfg_reg <= `CSC_CFG_RESET;
					o_state <= ST_PWRDN;
					status_reg <= 4'h0;
					busy_reg <= 1'b0;
					o_ready <= 1'b1;
					conv_clear <= 1'b1;
					for (i = 0; i < 4; i = i + 1)
						res_reg[i] <= 16'h0000;
				end else if (opstate_pend_v) begin
					opstate_reg[`CSC_OPST_PWRDN] <= opstate_pend[`CSC_OPST_PWRDN];
					if (nfield == `CSC_FLD_CFG || nfield == `CSC_FLD_MEAS)
						opstate_reg[`CSC_OPST_FLD_HI:`CSC_OPST_FLD_LO] <= nfield;
					o_state <= nst;
					if (o_state == ST_MEAS && nst != ST_MEAS) begin
						// Abort happens in this cycle, not at the next tick
						busy_reg <= 1'b0;
						o_ready <= 1'b1;
						conv_clear <= 1'b1;
						opstate_reg[`CSC_OPST_SS] <= 1'b0;
						status_reg <= 4'h0;
						for (i = 0; i < 4; i = i + 1)
							res_reg[i] <= 16'h0000;
					end else if (nst == ST_MEAS && opstate_pend[`CSC_OPST_SS] && !busy_reg) begin
						busy_reg <= 1'b1;
						cnt_reg <= {CNT_W{1'b0}};
						conv_clear <= 1'b1;
						o_ready <= 1'b0;
						opstate_reg[`CSC_OPST_SS] <= 1'b1;
						status_reg[`CSC_ST_DONE] <= 1'b0;
						status_reg[`CSC_ST_BUSY] <= 1'b1;
					end
				end
			end
		end
	end

	// Read port: one cycle answer, blocked registers read as zero
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rd_data <= 16'h0000;
			o_rd_valid <= 1'b0;
			o_access_err <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_valid;
			o_access_err <= i_rd_valid && !rd_allowed(i_rd_addr, o_state);
			o_rd_data <= 16'h0000;
			if (i_rd_valid && rd_allowed(i_rd_addr, o_state)) begin
				case (i_rd_addr)
					`CSC_ADR_OPST: o_rd_data <= {8'h00, opstate_reg};
					`CSC_ADR_STATUS: o_rd_data <= {12'h000, status_reg};
					`CSC_ADR_TEMP: o_rd_data <= res_reg[3];
					`CSC_ADR_RES1: o_rd_data <= res_reg[0];
					`CSC_ADR_RES2: o_rd_data <= res_reg[1];
					`CSC_ADR_RES3: o_rd_data <= res_reg[2];
					`CSC_ADR_CFG1: o_rd_data <= {8'h00, cfg_reg};
					default: o_rd_data <= 16'h0000;
				endcase
			end
		end
	end

endmodule
